// file: design/atx_top.sv
// Accumulator transfer instruction execution with Avalon-MM register access
//
// Operation
// - Comparator mode: B to upper, A lower
// - Conversion mode: comparator write does nothing
// - Mode is converter control bit three
// - First, second interrupt control into accumulator
// - Third interrupt control into accumulator bit0
// - Serial control register into accumulator
// - Each wakeup control register into accumulator
// - First display control into accumulator
// - Result low bits to A3,A2; clear rest
// - RAM at pointer to A; X xor immediate
// - Clock control register into accumulator
// - Each pull-up control register into accumulator
// - First converter control into accumulator
// - One word, one cycle, no carry/skip
`timescale 1ns/10ps
module atx_top (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        instr_valid,
  input  wire logic [9:0]  instr_word,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic      [3:0]  acc,
  output logic      [3:0]  reg_b,
  output logic      [3:0]  reg_x,
  output logic      [7:0]  comparator_value,
  output logic             instr_done,
  output logic             skip_next
);

  typedef struct packed {
    logic [3:0]                                acc;
    logic [3:0]                                b;
    logic [3:0]                                x;
    logic [atx_pkg::DP_BITS-1:0]               dp;
    logic [atx_pkg::NUM_CTL-1:0][3:0]          ctl;
    logic [atx_pkg::CONV_BITS-1:0]             conv;
    logic [atx_pkg::RAM_WORDS-1:0][3:0]        ram;
    logic                                      done;
    logic                                      skip;
    logic                                      wait_req;
    logic [31:0]                               rdata;
  } atx_top_s;

  // Waitrequest is high out of reset so no access completes early
  localparam atx_top_s RST_STATE = '{wait_req: 1'b1, default: '0};

  atx_top_s q;
  atx_top_s next_q;

  atx_op_if opif ();

  logic [7:0] cmp_q;
  logic       cmp_load;

  atx_decode u_decode (
    .instr_valid (instr_valid),
    .instr_word  (instr_word),
    .opif        (opif)
  );

  always_comb begin
    cmp_load = opif.valid && (opif.op == atx_pkg::ATX_OP_CMP_WRITE);
  end

  atx_cmp u_cmp (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .load      (cmp_load),
    .mode_bit  (q.ctl[atx_pkg::REG_CONV_CTL][atx_pkg::MODE_BIT]),
    .hi        (q.b),
    .lo        (q.acc),
    .cmp_value (cmp_q)
  );

  // True for indices held in the control nibble array
  function automatic logic is_ctl(input logic [4:0] a);
    return a <= atx_pkg::REG_CONV_CTL;
  endfunction

  function automatic logic [3:0] ctl_mask(input logic [4:0] a);
    return (a == atx_pkg::REG_IC3) ? atx_pkg::IC3_MASK : 4'hF;
  endfunction

  function automatic logic [31:0] read_word(input atx_top_s s,
                                            input logic [4:0] a,
                                            input logic [7:0] cmp);
    logic [31:0] r;
    r = atx_pkg::RD_UNMAPPED;
    if (is_ctl(a)) begin
      r = {28'h000_0000, s.ctl[a[3:0]] & ctl_mask(a)};
    end else begin
      unique case (a)
        atx_pkg::REG_CONV:     r = {22'h00_0000, s.conv};
        atx_pkg::REG_CMP:      r = {24'h00_0000, cmp};
        atx_pkg::REG_CORE:     r = {20'h0_0000, s.x, s.b, s.acc};
        atx_pkg::REG_DP:       r = {28'h000_0000, s.dp};
        atx_pkg::REG_RAM_DATA: r = {28'h000_0000, s.ram[s.dp]};
        default:               r = atx_pkg::RD_UNMAPPED;
      endcase
    end
    return r;
  endfunction

  always_comb begin
    next_q      = q;
    next_q.done = 1'b0;
    next_q.skip = 1'b0;

    // Bus slave: one wait cycle, then the access completes
    next_q.wait_req = 1'b1;
    if ((avs_read || avs_write) && q.wait_req) begin
      next_q.wait_req = 1'b0;
      if (avs_read) begin
        next_q.rdata = read_word(q, avs_address, cmp_q);
      end
    end

    // Writes take effect at the edge where waitrequest is seen low
    if (avs_write && !q.wait_req) begin
      if (is_ctl(avs_address)) begin
        next_q.ctl[avs_address[3:0]] = avs_writedata[3:0] & ctl_mask(avs_address);
      end else begin
        unique case (avs_address)
          atx_pkg::REG_CONV: begin
            next_q.conv = avs_writedata[atx_pkg::CONV_BITS-1:0];
          end
          atx_pkg::REG_CORE: begin
            next_q.acc = avs_writedata[3:0];
            next_q.b   = avs_writedata[7:4];
            next_q.x   = avs_writedata[11:8];
          end
          atx_pkg::REG_DP: begin
            next_q.dp = avs_writedata[atx_pkg::DP_BITS-1:0];
          end
          atx_pkg::REG_RAM_DATA: begin
            next_q.ram[q.dp] = avs_writedata[3:0];
          end
          default: begin
          end
        endcase
      end
    end

    // Instruction wins over a bus write in the same cycle
    if (opif.valid) begin
      next_q.done = 1'b1;
      unique case (opif.op)
        atx_pkg::ATX_OP_CMP_WRITE: begin
          // Comparator register only; core state unchanged
          next_q.acc = next_q.acc;
        end
        atx_pkg::ATX_OP_RD_IC1: begin
          next_q.acc = q.ctl[atx_pkg::REG_IC1];
        end
        atx_pkg::ATX_OP_RD_IC2: begin
          next_q.acc = q.ctl[atx_pkg::REG_IC2];
        end
        atx_pkg::ATX_OP_RD_IC3: begin
          next_q.acc = {3'b000, q.ctl[atx_pkg::REG_IC3][0]};
        end
        atx_pkg::ATX_OP_RD_SERIAL: begin
          next_q.acc = q.ctl[atx_pkg::REG_SERIAL];
        end
        atx_pkg::ATX_OP_RD_WK0: begin
          next_q.acc = q.ctl[atx_pkg::REG_WK0];
        end
        atx_pkg::ATX_OP_RD_WK1: begin
          next_q.acc = q.ctl[atx_pkg::REG_WK1];
        end
        atx_pkg::ATX_OP_RD_WK2: begin
          next_q.acc = q.ctl[atx_pkg::REG_WK2];
        end
        atx_pkg::ATX_OP_RD_DISP: begin
          next_q.acc = q.ctl[atx_pkg::REG_DISP];
        end
        atx_pkg::ATX_OP_RD_CONV_LOW: begin
          next_q.acc = {q.conv[1:0], 2'b00};
        end
        atx_pkg::ATX_OP_MEM_READ: begin
          next_q.acc = q.ram[q.dp];
          next_q.x   = q.x ^ opif.imm;
        end
        atx_pkg::ATX_OP_RD_CLOCK: begin
          next_q.acc = q.ctl[atx_pkg::REG_CLOCK];
        end
        atx_pkg::ATX_OP_RD_PU0: begin
          next_q.acc = q.ctl[atx_pkg::REG_PU0];
        end
        atx_pkg::ATX_OP_RD_PU1: begin
          next_q.acc = q.ctl[atx_pkg::REG_PU1];
        end
        atx_pkg::ATX_OP_RD_CONV_CTL: begin
          next_q.acc = q.ctl[atx_pkg::REG_CONV_CTL];
        end
        atx_pkg::ATX_OP_NONE: begin
          next_q.done = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      q <= RST_STATE;
    end else begin
      q <= next_q;
    end
  end

  assign avs_readdata     = q.rdata;
  assign avs_waitrequest  = q.wait_req;
  assign acc              = q.acc;
  assign reg_b            = q.b;
  assign reg_x            = q.x;
  assign comparator_value = cmp_q;
  assign instr_done       = q.done;
  assign skip_next        = q.skip;

endmodule

// file: design/atx_pkg.sv
// Constants, opcodes and register map of the accumulator transfer block
package atx_pkg;

  localparam int OPC_BITS  = 10;
  localparam int NIB_BITS  = 4;
  localparam int RAM_WORDS = 16;
  localparam int DP_BITS   = 4;
  localparam int CONV_BITS = 10;
  localparam int CMP_BITS  = 8;
  localparam int NUM_CTL   = 12;
  localparam int ADDR_BITS = 5;
  localparam int BUS_BITS  = 32;

  // Opcodes of the transfer group
  localparam logic [9:0] OPC_CMP_WRITE   = 10'h0_239;
  localparam logic [9:0] OPC_RD_IC1      = 10'h0_253;
  localparam logic [9:0] OPC_RD_IC2      = 10'h0_254;
  localparam logic [9:0] OPC_RD_IC3      = 10'h0_255;
  localparam logic [9:0] OPC_RD_SERIAL   = 10'h0_262;
  localparam logic [9:0] OPC_RD_WK0      = 10'h0_256;
  localparam logic [9:0] OPC_RD_WK1      = 10'h0_259;
  localparam logic [9:0] OPC_RD_WK2      = 10'h0_25A;
  localparam logic [9:0] OPC_RD_DISP     = 10'h0_24A;
  localparam logic [9:0] OPC_RD_CONV_LOW = 10'h0_249;
  localparam logic [9:0] OPC_RD_CLOCK    = 10'h0_252;
  localparam logic [9:0] OPC_RD_PU0      = 10'h0_257;
  localparam logic [9:0] OPC_RD_PU1      = 10'h0_25E;
  localparam logic [9:0] OPC_RD_CONV_CTL = 10'h0_244;
  // Memory read: upper six bits fixed, low four bits are the immediate
  localparam logic [5:0] OPC_MEM_READ_HI = 6'h2C;

  // Converter mode bit inside the first converter control register
  localparam int MODE_BIT = 3;

  // Register word indices; byte address is four times the index
  localparam logic [4:0] REG_IC1       = 5'h00;
  localparam logic [4:0] REG_IC2       = 5'h01;
  localparam logic [4:0] REG_IC3       = 5'h02;
  localparam logic [4:0] REG_SERIAL    = 5'h03;
  localparam logic [4:0] REG_WK0       = 5'h04;
  localparam logic [4:0] REG_WK1       = 5'h05;
  localparam logic [4:0] REG_WK2       = 5'h06;
  localparam logic [4:0] REG_DISP      = 5'h07;
  localparam logic [4:0] REG_CLOCK     = 5'h08;
  localparam logic [4:0] REG_PU0       = 5'h09;
  localparam logic [4:0] REG_PU1       = 5'h0A;
  localparam logic [4:0] REG_CONV_CTL  = 5'h0B;
  localparam logic [4:0] REG_CONV      = 5'h0C;
  localparam logic [4:0] REG_CMP       = 5'h0D;
  localparam logic [4:0] REG_CORE      = 5'h0E;
  localparam logic [4:0] REG_DP        = 5'h0F;
  localparam logic [4:0] REG_RAM_DATA  = 5'h10;

  localparam logic [3:0]  IC3_MASK     = 4'h1;
  localparam logic [3:0]  RST_NIBBLE   = 4'h0;
  localparam logic [31:0] RD_UNMAPPED  = 32'h0000_0000;

  typedef enum logic [4:0] {
    ATX_OP_NONE,
    ATX_OP_CMP_WRITE,
    ATX_OP_RD_IC1,
    ATX_OP_RD_IC2,
    ATX_OP_RD_IC3,
    ATX_OP_RD_SERIAL,
    ATX_OP_RD_WK0,
    ATX_OP_RD_WK1,
    ATX_OP_RD_WK2,
    ATX_OP_RD_DISP,
    ATX_OP_RD_CONV_LOW,
    ATX_OP_MEM_READ,
    ATX_OP_RD_CLOCK,
    ATX_OP_RD_PU0,
    ATX_OP_RD_PU1,
    ATX_OP_RD_CONV_CTL
  } atx_op_e;

endpackage

// file: design/atx_op_if.sv
// Decoded instruction carried from the decoder to the execution logic
`timescale 1ns/10ps
interface atx_op_if;
  logic                valid;
  atx_pkg::atx_op_e    op;
  logic [3:0]          imm;

  modport dec (output valid, output op, output imm);
  modport exe (input valid, input op, input imm);
endinterface

// file: design/atx_decode.sv
// Opcode decoder of the accumulator transfer group
`timescale 1ns/10ps
module atx_decode (
  input  wire logic       instr_valid,
  input  wire logic [9:0] instr_word,
  atx_op_if.dec           opif
);

  function automatic atx_pkg::atx_op_e decode(input logic [9:0] w);
    atx_pkg::atx_op_e r;
    r = atx_pkg::ATX_OP_NONE;
    if (w[9:4] == atx_pkg::OPC_MEM_READ_HI) begin
      r = atx_pkg::ATX_OP_MEM_READ;
    end else begin
      unique case (w)
        atx_pkg::OPC_CMP_WRITE:   r = atx_pkg::ATX_OP_CMP_WRITE;
        atx_pkg::OPC_RD_IC1:      r = atx_pkg::ATX_OP_RD_IC1;
        atx_pkg::OPC_RD_IC2:      r = atx_pkg::ATX_OP_RD_IC2;
        atx_pkg::OPC_RD_IC3:      r = atx_pkg::ATX_OP_RD_IC3;
        atx_pkg::OPC_RD_SERIAL:   r = atx_pkg::ATX_OP_RD_SERIAL;
        atx_pkg::OPC_RD_WK0:      r = atx_pkg::ATX_OP_RD_WK0;
        atx_pkg::OPC_RD_WK1:      r = atx_pkg::ATX_OP_RD_WK1;
        atx_pkg::OPC_RD_WK2:      r = atx_pkg::ATX_OP_RD_WK2;
        atx_pkg::OPC_RD_DISP:     r = atx_pkg::ATX_OP_RD_DISP;
        atx_pkg::OPC_RD_CONV_LOW: r = atx_pkg::ATX_OP_RD_CONV_LOW;
        atx_pkg::OPC_RD_CLOCK:    r = atx_pkg::ATX_OP_RD_CLOCK;
        atx_pkg::OPC_RD_PU0:      r = atx_pkg::ATX_OP_RD_PU0;
        atx_pkg::OPC_RD_PU1:      r = atx_pkg::ATX_OP_RD_PU1;
        atx_pkg::OPC_RD_CONV_CTL: r = atx_pkg::ATX_OP_RD_CONV_CTL;
        default:                  r = atx_pkg::ATX_OP_NONE;
      endcase
    end
    return r;
  endfunction

  always_comb begin
    opif.op    = decode(instr_word);
    opif.valid = instr_valid && (opif.op != atx_pkg::ATX_OP_NONE);
    opif.imm   = instr_word[3:0];
  end

endmodule

// file: design/atx_cmp.sv
// Comparator register loaded by the comparator write instruction
`timescale 1ns/10ps
module atx_cmp (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       load,
  input  wire logic       mode_bit,
  input  wire logic [3:0] hi,
  input  wire logic [3:0] lo,
  output logic      [7:0] cmp_value
);

  typedef struct packed {
    logic [7:0] value;
  } atx_cmp_s;

  atx_cmp_s q;
  atx_cmp_s next_q;

  always_comb begin
    next_q = q;
    // Conversion mode turns the instruction into a no-operation
    if (load && mode_bit) begin
      next_q.value = {hi, lo};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign cmp_value = q.value;

endmodule

// file: testbench/atx_top_props.sv
// Checker of the accumulator transfer block
`timescale 1ns/10ps
module atx_top_props (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic        instr_valid,
  input wire logic [9:0]  instr_word,
  input wire logic [4:0]  avs_address,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic        avs_waitrequest,
  input wire logic [3:0]  acc,
  input wire logic [3:0]  reg_b,
  input wire logic [3:0]  reg_x,
  input wire logic [7:0]  comparator_value,
  input wire logic        instr_done,
  input wire logic        skip_next
);
  logic       mode_q;
  logic       is_mem;
  logic       grp;
  logic [3:0] imm;
  logic       cmp_op;
  assign is_mem = instr_word[9:4] == atx_pkg::OPC_MEM_READ_HI;
  assign imm    = instr_word[3:0];
  assign cmp_op = instr_valid && instr_word == atx_pkg::OPC_CMP_WRITE;
  assign grp    = is_mem || (instr_word inside {atx_pkg::OPC_CMP_WRITE, atx_pkg::OPC_RD_IC1,
    atx_pkg::OPC_RD_IC2, atx_pkg::OPC_RD_IC3, atx_pkg::OPC_RD_SERIAL, atx_pkg::OPC_RD_WK0,
    atx_pkg::OPC_RD_WK1, atx_pkg::OPC_RD_WK2, atx_pkg::OPC_RD_DISP, atx_pkg::OPC_RD_CONV_LOW,
    atx_pkg::OPC_RD_CLOCK, atx_pkg::OPC_RD_PU0, atx_pkg::OPC_RD_PU1, atx_pkg::OPC_RD_CONV_CTL});
  // Mode bit is internal, so mirror it from completed bus writes
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mode_q <= 1'b0;
    end else if (avs_write && !avs_waitrequest && avs_address == atx_pkg::REG_CONV_CTL) begin
      mode_q <= avs_writedata[atx_pkg::MODE_BIT];
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_never_skip: assert property (skip_next == 1'b0)
    else $error("skip raised");
  a_done_follows: assert property (instr_valid && grp |=> instr_done)
    else $error("no done pulse");
  a_unknown_quiet: assert property (instr_valid && !grp |=> !instr_done)
    else $error("done on unknown opcode");
  a_done_cause: assert property (instr_done |-> $past(instr_valid) && $past(grp))
    else $error("done without cause");
  a_cmp_load: assert property (cmp_op && mode_q |=>
    comparator_value == {$past(reg_b), $past(acc)}) else $error("comparator not loaded");
  a_cmp_idle: assert property (cmp_op && !mode_q && !avs_write |=>
    $stable(comparator_value) && $stable(acc) && $stable(reg_x)) else $error("noop changed");
  a_mem_xor: assert property (instr_valid && is_mem |=>
    reg_x == ($past(reg_x) ^ $past(imm))) else $error("x not xored");
  a_low_cleared: assert property (instr_valid && instr_word == atx_pkg::OPC_RD_CONV_LOW |=>
    acc[1:0] == 2'b00) else $error("low bits not clear");
  a_ic3_upper: assert property (instr_valid && instr_word == atx_pkg::OPC_RD_IC3 |=>
    acc[3:1] == 3'b000) else $error("upper bits set");
endmodule
bind atx_top atx_top_props u_props (.ref_clk(ref_clk), .reset(reset),
  .instr_valid(instr_valid), .instr_word(instr_word), .avs_address(avs_address),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
  .acc(acc), .reg_b(reg_b), .reg_x(reg_x), .comparator_value(comparator_value),
  .instr_done(instr_done), .skip_next(skip_next));

// file: testbench/atx_top_test.sv
// Self-checking bench of the accumulator transfer block
`timescale 1ns/10ps
module atx_top_test;
  logic        ref_clk;
  logic        reset;
  logic        instr_valid;
  logic [9:0]  instr_word;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [3:0]  acc;
  logic [3:0]  reg_b;
  logic [3:0]  reg_x;
  logic [7:0]  comparator_value;
  logic        instr_done;
  logic        skip_next;
  logic [31:0] r [16];
  logic [3:0]  ram [16];
  logic [19:0] q_ins [$];
  logic [31:0] q_rd [$];
  logic [31:0] seed;
  int          error_cnt;
  int          n_compared;
  logic [9:0]  ops [13] = '{atx_pkg::OPC_RD_IC1, atx_pkg::OPC_RD_IC2, atx_pkg::OPC_RD_IC3,
    atx_pkg::OPC_RD_SERIAL, atx_pkg::OPC_RD_WK0, atx_pkg::OPC_RD_WK1, atx_pkg::OPC_RD_WK2,
    atx_pkg::OPC_RD_DISP, atx_pkg::OPC_RD_CONV_LOW, atx_pkg::OPC_RD_CLOCK,
    atx_pkg::OPC_RD_PU0, atx_pkg::OPC_RD_PU1, atx_pkg::OPC_RD_CONV_CTL};

  atx_top uut (.ref_clk(ref_clk), .reset(reset), .instr_valid(instr_valid),
    .instr_word(instr_word), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .acc(acc), .reg_b(reg_b), .reg_x(reg_x),
    .comparator_value(comparator_value), .instr_done(instr_done), .skip_next(skip_next));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [31:0] wmask(input logic [4:0] a);
    case (a)
      atx_pkg::REG_IC3:  return 32'h0000_0001;
      atx_pkg::REG_CONV: return 32'h0000_03FF;
      atx_pkg::REG_CMP:  return 32'h0000_00FF;
      atx_pkg::REG_CORE: return 32'h0000_0FFF;
      default:           return (a < 5'h10) ? 32'h0000_000F : 32'h0000_0000;
    endcase
  endfunction

  task automatic chk_ins(input logic [19:0] e, input logic [19:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value acc_b_x_cmp expected %h seen %h", e, g);
    end
  endtask

  task automatic chk_rd(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic complete_run();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic bus(input logic [4:0] a, input logic wr, input logic [31:0] d);
    int n;
    if (!wr) begin
      q_rd.push_back(a == atx_pkg::REG_RAM_DATA ? {28'h0, ram[r[15][3:0]]} : r[a[3:0]] & wmask(a));
    end
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      error_cnt++;
      complete_run();
    end else begin
      if (wr && a == atx_pkg::REG_RAM_DATA) ram[r[15][3:0]] = d[3:0];
      else if (wr && a < 5'h10 && a != atx_pkg::REG_CMP) r[a[3:0]] = d & wmask(a);
      @(posedge ref_clk);
    end
  endtask

  task automatic ins(input logic [9:0] w);
    logic [3:0] a;
    logic [3:0] b;
    logic [3:0] x;
    logic       hit;
    {x, b, a} = r[14][11:0];
    hit = 1'b1;
    case (w)
      atx_pkg::OPC_CMP_WRITE: if (r[11][atx_pkg::MODE_BIT]) r[13] = {24'h0, b, a};
      atx_pkg::OPC_RD_IC1:      a = r[0][3:0];
      atx_pkg::OPC_RD_IC2:      a = r[1][3:0];
      atx_pkg::OPC_RD_IC3:      a = {3'h0, r[2][0]};
      atx_pkg::OPC_RD_SERIAL:   a = r[3][3:0];
      atx_pkg::OPC_RD_WK0:      a = r[4][3:0];
      atx_pkg::OPC_RD_WK1:      a = r[5][3:0];
      atx_pkg::OPC_RD_WK2:      a = r[6][3:0];
      atx_pkg::OPC_RD_DISP:     a = r[7][3:0];
      atx_pkg::OPC_RD_CONV_LOW: a = {r[12][1:0], 2'h0};
      atx_pkg::OPC_RD_CLOCK:    a = r[8][3:0];
      atx_pkg::OPC_RD_PU0:      a = r[9][3:0];
      atx_pkg::OPC_RD_PU1:      a = r[10][3:0];
      atx_pkg::OPC_RD_CONV_CTL: a = r[11][3:0];
      default: begin
        hit = w[9:4] == atx_pkg::OPC_MEM_READ_HI;
        if (hit) a = ram[r[15][3:0]];
        if (hit) x = x ^ w[3:0];
      end
    endcase
    r[14] = {20'h0, x, b, a};
    if (hit) q_ins.push_back({a, b, x, r[13][7:0]});
    instr_valid <= 1'b1;
    instr_word <= w;
    @(posedge ref_clk);
  endtask

  task automatic idle();
    instr_valid <= 1'b0;
    @(posedge ref_clk);
  endtask

  always @(negedge ref_clk) begin
    if (instr_done === 1'b1) chk_ins(q_ins.size() ? q_ins.pop_front() : 20'hx_xxxx,
      {acc, reg_b, reg_x, comparator_value});
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) chk_rd("readdata",
      q_rd.size() ? q_rd.pop_front() : 32'hxxxx_xxxx, avs_readdata);
  end

  initial begin
    seed = 32'h0000_0008;
    error_cnt = 0;
    n_compared = 0;
    reset = 1'b1;
    instr_valid = 1'b0;
    instr_word = 10'h000;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    foreach (r[i]) r[i] = 32'h0000_0000;
    foreach (ram[i]) ram[i] = 4'h0;
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    for (int i = 0; i < 17; i++) bus(5'(i), 1'b0, 32'h0000_0000);
    // Every word written, unmapped and read-only places included
    for (int i = 0; i < 32; i++) bus(5'(i), 1'b1, rnd());
    for (int i = 0; i < 32; i++) bus(5'(i), 1'b0, 32'h0000_0000);
    foreach (ops[i]) ins(ops[i]);
    idle();
    for (int m = 0; m < 3; m++) begin
      bus(atx_pkg::REG_CONV_CTL, 1'b1,
        (m[0] ? 32'h0000_0008 : 32'h0000_0000) | (rnd() & 32'h0000_0007));
      bus(atx_pkg::REG_CORE, 1'b1, rnd());
      ins(atx_pkg::OPC_CMP_WRITE);
      ins(atx_pkg::OPC_RD_CONV_CTL);
      idle();
      bus(atx_pkg::REG_CMP, 1'b0, 32'h0000_0000);
    end
    for (int i = 0; i < 16; i++) begin
      bus(atx_pkg::REG_DP, 1'b1, 32'(i));
      bus(atx_pkg::REG_RAM_DATA, 1'b1, rnd());
      bus(atx_pkg::REG_RAM_DATA, 1'b0, 32'h0000_0000);
      ins({atx_pkg::OPC_MEM_READ_HI, 4'(i)});
      ins({atx_pkg::OPC_MEM_READ_HI, 4'(rnd())});
      ins(10'h3FF);
      idle();
    end
    repeat (2) @(posedge ref_clk);
    chk_rd("pending", 32'h0000_0000, 32'(q_ins.size() + q_rd.size()));
    complete_run();
  end
endmodule
